// >>> hw/rcs_pkg.sv
// constants, types and field layout of the reset configuration sequencer
//
// Contract
// [RULE_01] latch strap pins at master reset release
// [RULE_02] build default image, pins untouched
// [RULE_03] strap picks protocol; SPI defaults four-wire
// [RULE_04] apply EEPROM update, then restart sequence
// [RULE_05] load strap-selected OTP config, report outcome
// [RULE_06] OTP config overwrites only listed registers
// [RULE_07] stored data writes all trigger bytes
// [RULE_08] programmed PLL divider starts concurrent calibration
// [RULE_09] loaded registers reselect slave protocol
// [RULE_10] skip bad EEPROM blocks, stop at first
// [RULE_11] EEPROM config only without valid OTP; code searches EEPROM blocks whenever parts were found, even after valid OTP
// [RULE_12] run OTP hotfix after configuration searches
// [RULE_13] completion steps run in fixed order
// [RULE_14] status bits report reset failures
// [RULE_15] host waits 15ms, EEPROM load disabled
// [RULE_16] host waits 150ms, no EEPROM answers
// [RULE_17] EEPROM present: wait follows payload formula
// [RULE_18] power policy: boot minimum, drop unneeded
// [RULE_19] master port loads; slave port after reset
// [RULE_20] slave config changes commit per burst
// [RULE_21] shared pins carry SPI or address roles
// [RULE_22] 16-bit space, upper half user
// [RULE_23] full offset or paged addressing
// [RULE_24] probe eight addresses at three speeds
// [RULE_25] check blocks at two EEPROM offsets
// [RULE_26] slave ignored until enabled; done flagged
package rcs_pkg;
  // ==========================================================
  // straps
  localparam int STRAP_W = 6;
  localparam int STRAP_SPI = 0;
  localparam int STRAP_EE_EN = 1;
  localparam int STRAP_CFG_LSB = 2;
  localparam int CFG_NUM_W = 4;
  // ==========================================================
  // eeprom search
  localparam logic [6:0] EE_ADDR_BASE = 7'h50;
  localparam logic [2:0] EE_IDX_LAST = 3'h7;
  localparam logic [1:0] EE_SPD_1M = 2'h0;
  localparam logic [1:0] EE_SPD_100K = 2'h2;
  localparam logic [15:0] EE_OFF_LOW = 16'h0000;
  localparam logic [15:0] EE_OFF_HIGH = 16'hf000;
  // ==========================================================
  // address space
  localparam int ADDR_W = 16;
  localparam int USER_BIT = 15;
  localparam int I2C_1B_W = 8;
  localparam int SPI_1B_W = 7;
  localparam int SPI_2B_W = 15;
  // ==========================================================
  // power policy
  localparam int NFUNC = 4;
  localparam logic [NFUNC-1:0] BOOT_NEED = 4'h3;
  localparam logic [1:0] PWR_OFF = 2'h0;
  localparam logic [1:0] PWR_GATED = 2'h1;
  localparam logic [1:0] PWR_RUN = 2'h2;
  // ==========================================================
  // types
  typedef struct packed {
    logic proto_spi;
    logic spi_3wire;
    logic addr_2b;
  } rcs_ser_cfg_t;
  typedef struct packed {
    logic otp_missing;
    logic otp_bad_crc;
    logic no_eeprom;
    logic ee_no_cfg;
    logic no_cfg;
    logic upd_applied;
  } rcs_status_t;
endpackage

// >>> hw/rcs_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module rcs_sync #(
  parameter int W = 1
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      q_o <= '0;
    end else if (ce_i) begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

// >>> hw/rcs_addr.sv
// register address former for the slave port
`timescale 1ns/100ps
module rcs_addr (
  // configuration
  input wire rcs_pkg::rcs_ser_cfg_t cfg_i,
  input wire logic [rcs_pkg::ADDR_W-1:0] page_i,
  // transaction offset
  input wire logic [rcs_pkg::ADDR_W-1:0] off_i,
  output logic [rcs_pkg::ADDR_W-1:0] addr_o,
  output logic user_o
);
  localparam int AW = rcs_pkg::ADDR_W;
  localparam int I1 = rcs_pkg::I2C_1B_W;
  localparam int S1 = rcs_pkg::SPI_1B_W;
  localparam int S2 = rcs_pkg::SPI_2B_W;
  wire [AW-1:0] i2c_1b = {page_i[AW-1:I1], off_i[I1-1:0]};
  wire [AW-1:0] spi_1b = {page_i[AW-1:S1], off_i[S1-1:0]};
  wire [AW-1:0] spi_2b = {page_i[AW-1:S2], off_i[S2-1:0]};
  wire [AW-1:0] paged = cfg_i.proto_spi ? spi_1b : i2c_1b;
  wire [AW-1:0] full = cfg_i.proto_spi ? spi_2b : off_i;

  assign addr_o = cfg_i.addr_2b ? full : paged; // see [RULE_23]
  assign user_o = addr_o[rcs_pkg::USER_BIT]; // see [RULE_22]
endmodule

// >>> hw/rcs_top.sv
// reset and initial configuration sequencer
`timescale 1ns/100ps
module rcs_top (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  // strap pins
  input wire logic [rcs_pkg::STRAP_W-1:0] strap_i,
  // register image
  output logic img_req_o,
  input wire logic img_done_i,
  output logic apply_req_o,
  input wire logic apply_done_i,
  // otp
  output logic otp_req_o,
  output logic [rcs_pkg::CFG_NUM_W-1:0] otp_cfg_num_o,
  input wire logic otp_ack_i,
  input wire logic otp_found_i,
  input wire logic otp_crc_ok_i,
  input wire logic otp_system_analog_pll_fb_i,
  input wire rcs_pkg::rcs_ser_cfg_t otp_ser_i,
  input wire logic hotfix_present_i,
  output logic hotfix_req_o,
  input wire logic hotfix_done_i,
  // eeprom access through the master port
  output logic ee_probe_req_o,
  output logic [6:0] ee_addr_o,
  output logic [1:0] ee_speed_o,
  input wire logic ee_probe_ack_i,
  input wire logic ee_found_i,
  output logic ee_blk_req_o,
  output logic [rcs_pkg::ADDR_W-1:0] ee_blk_off_o,
  output logic ee_blk_upd_o,
  input wire logic ee_blk_ack_i,
  input wire logic ee_blk_valid_i,
  // system pll
  output logic system_analog_pll_cal_o,
  output logic system_analog_pll_lock_req_o,
  input wire logic system_analog_pll_locked_i,
  // enables and status
  output logic serial_en_o,
  output logic outputs_en_o,
  output logic monitors_en_o,
  output logic alarms_en_o,
  output logic done_o,
  output rcs_pkg::rcs_status_t status_o,
  output logic [rcs_pkg::CFG_NUM_W-1:0] cfg_num_o,
  // power policy
  input wire logic [rcs_pkg::NFUNC-1:0] func_need_i,
  input wire logic [rcs_pkg::NFUNC-1:0] func_keep_i,
  output logic [rcs_pkg::NFUNC-1:0][1:0] pwr_state_o,
  // slave port configuration and paging
  input wire logic ser_wr_i,
  input wire rcs_pkg::rcs_ser_cfg_t ser_wdata_i,
  input wire logic page_wr_i,
  input wire logic [rcs_pkg::ADDR_W-1:0] page_wdata_i,
  input wire logic burst_end_i,
  input wire logic [rcs_pkg::ADDR_W-1:0] txn_off_i,
  output rcs_pkg::rcs_ser_cfg_t ser_cfg_o,
  output logic [rcs_pkg::ADDR_W-1:0] reg_addr_o,
  output logic user_space_o,
  // shared slave pins
  input wire logic select_or_addr0_pin_i,
  input wire logic data_in_or_addr1_pin_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_o,
  input wire logic slv_sdo_i,
  input wire logic slv_sdo_en_i,
  output logic slave_addr_bit0_o,
  output logic slave_addr_bit1_o,
  output logic spi_cs_n_o,
  output logic spi_di_o,
  output logic sda_in_o
);
  localparam int SW = rcs_pkg::STRAP_W;
  localparam int AW = rcs_pkg::ADDR_W;
  localparam int CW = rcs_pkg::CFG_NUM_W;

  typedef enum logic [3:0] {
    ST_CAPTURE, ST_IMAGE, ST_PROBE, ST_UPD, ST_OTP, ST_EECFG,
    ST_HOTFIX, ST_PLL, ST_SERIAL, ST_APPLY, ST_MON, ST_ALARM, ST_DONE
  } rcs_state_t;

  // ==========================================================
  // reset release and pin synchronisers
  logic rst_meta_reg;
  logic rst_n;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else if (clk_en_i) begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // pins are reset by the raw reset so their values are settled by the
  // time the released copy lets the capture state run
  logic [SW+2:0] pins_sync;
  rcs_sync #(.W(SW + 3)) u_sync (
    .clk_i(sys_clk_i),
    .rst_n_i(arst_n_i),
    .ce_i(clk_en_i),
    .d_i({sdio_i, data_in_or_addr1_pin_i, select_or_addr0_pin_i,
          strap_i}),
    .q_o(pins_sync)
  );
  wire [SW-1:0] strap_sync = pins_sync[SW-1:0];
  wire pin0_sync = pins_sync[SW];
  wire pin1_sync = pins_sync[SW+1];
  wire sdio_sync = pins_sync[SW+2];

  // ==========================================================
  // sequencer state
  rcs_state_t state_reg, state_next;
  logic [SW-1:0] strap_reg, strap_next;
  logic req_reg, req_next;
  logic [2:0] idx_reg, idx_next;
  logic [1:0] spd_reg, spd_next;
  logic hi_reg, hi_next;
  logic [7:0] mask_reg, mask_next;
  logic upd_done_reg, upd_done_next;
  logic otp_ok_reg, otp_ok_next;
  logic ee_ok_reg, ee_ok_next;
  logic cal_next;
  rcs_pkg::rcs_ser_cfg_t ser_reg, ser_next;
  rcs_pkg::rcs_status_t st_reg, st_next;
  logic [CW-1:0] num_reg, num_next;
  logic [3:0] en_reg, en_next;

  // ==========================================================
  // staged slave writes, committed only at the end of a burst
  rcs_pkg::rcs_ser_cfg_t stage_reg;
  logic stage_vld_reg;
  logic [AW-1:0] page_stage_reg;
  logic page_vld_reg;
  logic [AW-1:0] page_reg;
  wire slave_ok = en_reg[0];
  wire commit = burst_end_i & slave_ok;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      stage_reg <= '0;
      stage_vld_reg <= 1'b0;
      page_stage_reg <= '0;
      page_vld_reg <= 1'b0;
      page_reg <= '0;
    end else if (clk_en_i) begin
      if (ser_wr_i && slave_ok) begin // see [RULE_26]
        stage_reg <= ser_wdata_i;
      end
      stage_vld_reg <= (stage_vld_reg & ~commit) | (ser_wr_i & slave_ok);
      if (page_wr_i && slave_ok) begin
        page_stage_reg <= page_wdata_i;
      end
      page_vld_reg <= (page_vld_reg & ~commit) | (page_wr_i & slave_ok);
      if (commit && page_vld_reg) begin // see [RULE_23]
        page_reg <= page_stage_reg;
      end
    end
  end

  // ==========================================================
  // request acknowledge and loaded-config decode
  wire ee_en = strap_reg[rcs_pkg::STRAP_EE_EN];
  wire loaded = otp_ok_reg | ee_ok_reg;
  wire idx_last = (idx_reg == rcs_pkg::EE_IDX_LAST);
  wire spd_last = (spd_reg == rcs_pkg::EE_SPD_100K);
  wire any_found = (mask_reg != 8'h00) | ee_found_i;
  wire mask_hit = mask_reg[idx_reg];
  wire [CW-1:0] strap_cfg = strap_reg[rcs_pkg::STRAP_CFG_LSB +: CW];

  always_comb begin
    state_next = state_reg;
    strap_next = strap_reg;
    req_next = req_reg;
    idx_next = idx_reg;
    spd_next = spd_reg;
    hi_next = hi_reg;
    mask_next = mask_reg;
    upd_done_next = upd_done_reg;
    otp_ok_next = otp_ok_reg;
    ee_ok_next = ee_ok_reg;
    cal_next = 1'b0;
    ser_next = ser_reg;
    st_next = st_reg;
    num_next = num_reg;
    en_next = en_reg;
    case (state_reg)
      ST_CAPTURE: begin
        strap_next = strap_sync; // see [RULE_01]
        ser_next.proto_spi = strap_sync[rcs_pkg::STRAP_SPI]; // see [RULE_03]
        ser_next.spi_3wire = 1'b0; // see [RULE_03]
        ser_next.addr_2b = 1'b0;
        en_next = 4'h0;
        state_next = ST_IMAGE;
      end
      ST_IMAGE: begin
        // enables stay low, so pins keep their reset condition
        if (!req_reg) begin
          req_next = 1'b1; // see [RULE_02]
        end else if (img_done_i) begin
          req_next = 1'b0;
          idx_next = 3'h0;
          spd_next = rcs_pkg::EE_SPD_1M;
          mask_next = 8'h00;
          state_next = ee_en ? ST_PROBE : ST_OTP;
        end
      end
      ST_PROBE: begin
        if (!req_reg) begin
          req_next = 1'b1; // see [RULE_24]
        end else if (ee_probe_ack_i) begin
          req_next = 1'b0;
          if (ee_found_i) begin
            mask_next[idx_reg] = 1'b1;
          end
          idx_next = idx_reg + 3'h1;
          if (idx_last && any_found) begin
            state_next = upd_done_reg ? ST_OTP : ST_UPD;
          end else if (idx_last && spd_last) begin
            st_next.no_eeprom = 1'b1;
            state_next = ST_OTP;
          end else if (idx_last) begin
            spd_next = spd_reg + 2'h1; // see [RULE_24]
          end
        end
      end
      ST_UPD: begin
        if (!req_reg && mask_hit) begin
          req_next = 1'b1;
        end else if (!req_reg || ee_blk_ack_i) begin
          req_next = 1'b0;
          idx_next = idx_reg + 3'h1;
          if (req_reg && ee_blk_valid_i) begin
            st_next.upd_applied = 1'b1;
            upd_done_next = 1'b1;
            state_next = ST_CAPTURE; // see [RULE_04]
          end else if (idx_last) begin
            state_next = ST_OTP;
          end
        end
      end
      ST_OTP: begin
        if (!req_reg) begin
          req_next = 1'b1; // see [RULE_05]
        end else if (otp_ack_i) begin
          req_next = 1'b0;
          idx_next = 3'h0;
          hi_next = 1'b0;
          state_next = (ee_en && mask_reg != 8'h00) ? ST_EECFG : ST_HOTFIX;
          if (!otp_found_i) begin
            st_next.otp_missing = 1'b1; // see [RULE_05]
          end else if (!otp_crc_ok_i) begin
            st_next.otp_bad_crc = 1'b1; // see [RULE_05]
          end else begin
            otp_ok_next = 1'b1; // see [RULE_06]
            num_next = strap_cfg; // see [RULE_05]
            cal_next = otp_system_analog_pll_fb_i; // see [RULE_08]
            ser_next = otp_ser_i; // see [RULE_09]
          end
        end
      end
      ST_EECFG: begin
        if (!req_reg && mask_hit) begin
          req_next = 1'b1; // see [RULE_25]
        end else if (!req_reg || ee_blk_ack_i) begin
          req_next = 1'b0;
          hi_next = ~hi_reg & mask_hit;
          if (hi_reg || !mask_hit) begin
            idx_next = idx_reg + 3'h1;
          end
          if (req_reg && ee_blk_valid_i) begin
            ee_ok_next = 1'b1; // see [RULE_10]
            state_next = ST_HOTFIX;
          end else if (idx_last && (hi_reg || !mask_hit)) begin
            st_next.ee_no_cfg = 1'b1; // see [RULE_10]
            state_next = ST_HOTFIX;
          end
        end
      end
      ST_HOTFIX: begin
        if (!hotfix_present_i && !req_reg) begin
          state_next = ST_PLL;
        end else if (!req_reg) begin
          req_next = 1'b1; // see [RULE_12]
        end else if (hotfix_done_i) begin
          req_next = 1'b0;
          state_next = ST_PLL;
        end
      end
      ST_PLL: begin
        if (!loaded && !req_reg) begin
          state_next = ST_SERIAL;
        end else if (!req_reg) begin
          req_next = 1'b1; // see [RULE_13]
        end else if (system_analog_pll_locked_i) begin
          req_next = 1'b0;
          state_next = ST_SERIAL;
        end
      end
      ST_SERIAL: begin
        en_next[0] = 1'b1; // see [RULE_13]
        state_next = ST_APPLY;
      end
      ST_APPLY: begin
        if (!req_reg) begin
          req_next = 1'b1;
        end else if (apply_done_i) begin
          req_next = 1'b0;
          en_next[1] = 1'b1; // see [RULE_13]
          state_next = ST_MON;
        end
      end
      ST_MON: begin
        en_next[2] = 1'b1; // see [RULE_13]
        state_next = ST_ALARM;
      end
      ST_ALARM: begin
        en_next[3] = 1'b1; // see [RULE_13]
        st_next.no_cfg = ~loaded; // see [RULE_14]
        state_next = ST_DONE;
      end
      ST_DONE: begin
        if (commit && stage_vld_reg) begin
          ser_next = stage_reg; // see [RULE_20]
        end
      end
      default: begin
        state_next = ST_CAPTURE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_CAPTURE;
      strap_reg <= '0;
      req_reg <= 1'b0;
      idx_reg <= 3'h0;
      spd_reg <= rcs_pkg::EE_SPD_1M;
      hi_reg <= 1'b0;
      mask_reg <= 8'h00;
      upd_done_reg <= 1'b0;
      otp_ok_reg <= 1'b0;
      ee_ok_reg <= 1'b0;
      ser_reg <= '0;
      st_reg <= '0;
      num_reg <= '0;
      en_reg <= 4'h0;
    end else if (clk_en_i) begin
      state_reg <= state_next;
      strap_reg <= strap_next;
      req_reg <= req_next;
      idx_reg <= idx_next;
      spd_reg <= spd_next;
      hi_reg <= hi_next;
      mask_reg <= mask_next;
      upd_done_reg <= upd_done_next;
      otp_ok_reg <= otp_ok_next;
      ee_ok_reg <= ee_ok_next;
      ser_reg <= ser_next;
      st_reg <= st_next;
      num_reg <= num_next;
      en_reg <= en_next;
    end
  end

  // ==========================================================
  // registered request and status outputs
  wire in_blk = (state_next == ST_UPD) | (state_next == ST_EECFG);
  wire [AW-1:0] blk_off = hi_next ? rcs_pkg::EE_OFF_HIGH
                                  : rcs_pkg::EE_OFF_LOW;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      img_req_o <= 1'b0;
      apply_req_o <= 1'b0;
      otp_req_o <= 1'b0;
      otp_cfg_num_o <= '0;
      hotfix_req_o <= 1'b0;
      ee_probe_req_o <= 1'b0;
      ee_addr_o <= rcs_pkg::EE_ADDR_BASE;
      ee_speed_o <= rcs_pkg::EE_SPD_1M;
      ee_blk_req_o <= 1'b0;
      ee_blk_off_o <= rcs_pkg::EE_OFF_LOW;
      ee_blk_upd_o <= 1'b0;
      system_analog_pll_cal_o <= 1'b0;
      system_analog_pll_lock_req_o <= 1'b0;
    end else if (clk_en_i) begin
      img_req_o <= req_next & (state_next == ST_IMAGE);
      apply_req_o <= req_next & (state_next == ST_APPLY);
      otp_req_o <= req_next & (state_next == ST_OTP);
      otp_cfg_num_o <= strap_next[rcs_pkg::STRAP_CFG_LSB +: CW];
      hotfix_req_o <= req_next & (state_next == ST_HOTFIX);
      ee_probe_req_o <= req_next & (state_next == ST_PROBE);
      ee_addr_o <= rcs_pkg::EE_ADDR_BASE | {4'h0, idx_next};
      ee_speed_o <= spd_next;
      ee_blk_req_o <= req_next & in_blk;
      ee_blk_off_o <= blk_off; // see [RULE_25]
      ee_blk_upd_o <= (state_next == ST_UPD);
      system_analog_pll_cal_o <= cal_next; // see [RULE_08]
      system_analog_pll_lock_req_o <= req_next & (state_next == ST_PLL);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      serial_en_o <= 1'b0;
      outputs_en_o <= 1'b0;
      monitors_en_o <= 1'b0;
      alarms_en_o <= 1'b0;
      done_o <= 1'b0;
      status_o <= '0;
      cfg_num_o <= '0;
      ser_cfg_o <= '0;
    end else if (clk_en_i) begin
      serial_en_o <= en_next[0]; // see [RULE_19]
      outputs_en_o <= en_next[1];
      monitors_en_o <= en_next[2];
      alarms_en_o <= en_next[3];
      done_o <= (state_next == ST_DONE); // see [RULE_26]
      status_o <= st_next; // see [RULE_14]
      cfg_num_o <= num_next;
      ser_cfg_o <= ser_next;
    end
  end

  // ==========================================================
  // power policy: boot set until done, then software's indicators
  logic [rcs_pkg::NFUNC-1:0][1:0] pwr_next;
  genvar gi;
  generate
    for (gi = 0; gi < rcs_pkg::NFUNC; gi++) begin : g_pwr
      wire need = done_o ? func_need_i[gi] : rcs_pkg::BOOT_NEED[gi];
      wire keep = done_o & func_keep_i[gi];
      assign pwr_next[gi] = need ? rcs_pkg::PWR_RUN : // see [RULE_18]
                            (keep ? rcs_pkg::PWR_GATED : rcs_pkg::PWR_OFF);
    end
  endgenerate

  // ==========================================================
  // addressing and shared pin roles
  logic [AW-1:0] addr_w;
  logic user_w;
  rcs_addr u_addr (
    .cfg_i(ser_reg),
    .page_i(page_reg),
    .off_i(txn_off_i),
    .addr_o(addr_w),
    .user_o(user_w)
  );

  // i2c data is open drain: drive low only, released while disabled
  wire spi = ser_reg.proto_spi;
  wire sdio_drv = spi ? slv_sdo_en_i : ~slv_sdo_i;
  wire di_w = ser_reg.spi_3wire ? sdio_sync : pin1_sync;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pwr_state_o <= '0;
      reg_addr_o <= '0;
      user_space_o <= 1'b0;
      sdio_o <= 1'b0;
      sdio_oe_o <= 1'b0;
      slave_addr_bit0_o <= 1'b0;
      slave_addr_bit1_o <= 1'b0;
      spi_cs_n_o <= 1'b1;
      spi_di_o <= 1'b0;
      sda_in_o <= 1'b1;
    end else if (clk_en_i) begin
      pwr_state_o <= pwr_next;
      reg_addr_o <= addr_w; // see [RULE_22]
      user_space_o <= user_w; // see [RULE_22]
      sdio_o <= spi & slv_sdo_i; // see [RULE_21]
      sdio_oe_o <= slave_ok & sdio_drv; // see [RULE_26]
      slave_addr_bit0_o <= ~spi & pin0_sync; // see [RULE_21]
      slave_addr_bit1_o <= ~spi & pin1_sync; // see [RULE_21]
      spi_cs_n_o <= ~(spi & slave_ok) | pin0_sync; // see [RULE_21]
      spi_di_o <= spi & di_w;
      sda_in_o <= spi | sdio_sync;
    end
  end
endmodule

// >>> verif/rcs_sva.sv
// port assertions for the reset sequencer
`timescale 1ns/100ps
module rcs_sva (
  input wire logic sys_clk_i, arst_n_i, otp_req_o, otp_ack_i,
  input wire logic otp_found_i, otp_crc_ok_i, otp_system_analog_pll_fb_i, system_analog_pll_cal_o,
  input wire logic [rcs_pkg::CFG_NUM_W-1:0] otp_cfg_num_o, cfg_num_o,
  input wire rcs_pkg::rcs_status_t status_o,
  input wire logic ee_probe_req_o, ee_blk_req_o, serial_en_o,
  input wire logic outputs_en_o, monitors_en_o, alarms_en_o, done_o,
  input wire logic [6:0] ee_addr_o,
  input wire logic [rcs_pkg::ADDR_W-1:0] ee_blk_off_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  wire logic otp_ok;
  assign otp_ok = otp_req_o && otp_ack_i && otp_found_i && otp_crc_ok_i;
  serial_first_a:
    assert property ($rose(serial_en_o) |-> !outputs_en_o)
    else $error("outputs before serial port");
  outputs_next_a:
    assert property ($rose(outputs_en_o) |-> serial_en_o && !monitors_en_o)
    else $error("outputs enabled out of order");
  monitors_next_a:
    assert property ($rose(monitors_en_o) |-> outputs_en_o && !alarms_en_o)
    else $error("monitors enabled out of order");
  done_last_a:
    assert property (done_o |-> alarms_en_o && monitors_en_o)
    else $error("done before alarms");
  cal_cause_a:
    assert property (system_analog_pll_cal_o |-> $past(otp_ok && otp_system_analog_pll_fb_i))
    else $error("calibration without divider");
  cfg_report_a:
    assert property (otp_ok |=> cfg_num_o == $past(otp_cfg_num_o))
    else $error("loaded number not reported");
  crc_flag_a:
    assert property (otp_req_o && otp_ack_i && otp_found_i && !otp_crc_ok_i
      |=> status_o.otp_bad_crc)
    else $error("checksum failure not flagged");
  probe_addr_a:
    assert property (ee_probe_req_o |-> ee_addr_o[6:3] == 4'ha)
    else $error("probe outside address range");
  blk_off_a:
    assert property (ee_blk_req_o |-> ee_blk_off_o inside {16'h0000, 16'hf000})
    else $error("block offset wrong");
endmodule
bind rcs_top rcs_sva rcs_sva_i (.*);

// >>> verif/rcs_peer.sv
// far-side model: image, otp, eeprom and pll responders
`timescale 1ns/100ps
module rcs_peer (
  input wire logic sys_clk_i, img_req_o, apply_req_o, otp_req_o,
  input wire logic hotfix_req_o, ee_probe_req_o, ee_blk_req_o,
  input wire logic system_analog_pll_lock_req_o, ee_blk_upd_o,
  input wire logic [6:0] ee_addr_o,
  input wire logic [1:0] ee_speed_o, ee_spd,
  input wire logic [15:0] ee_blk_off_o,
  input wire logic [7:0] ee_mask,
  input wire logic [2:0] blk_ok,
  output logic img_done_i, apply_done_i, otp_ack_i, hotfix_done_i,
  output logic ee_probe_ack_i, ee_blk_ack_i, system_analog_pll_locked_i,
  output logic ee_found_i, ee_blk_valid_i
);
  logic [6:0] req;
  logic [6:0] ack = 7'h00;
  assign req = {img_req_o, apply_req_o, otp_req_o, hotfix_req_o,
    ee_probe_req_o, ee_blk_req_o, system_analog_pll_lock_req_o};
  assign {img_done_i, apply_done_i, otp_ack_i, hotfix_done_i,
    ee_probe_ack_i, ee_blk_ack_i, system_analog_pll_locked_i} = ack;
  // one answer pulse per held request; hotfix run here
  always @(posedge sys_clk_i) ack <= req & ~ack;
  // a part answers only at its own bus speed
  assign ee_found_i = ee_mask[ee_addr_o[2:0]] && ee_speed_o == ee_spd;
  // block validity follows blk_ok: bit 2 for updates, else the bit picked by offset bit 15
  assign ee_blk_valid_i = ee_blk_upd_o ? blk_ok[2] : blk_ok[ee_blk_off_o[15]];
endmodule

// >>> verif/tb.sv
// self-checking bench for the reset sequencer
`timescale 1ns/100ps
module tb;
  logic sys_clk_i, arst_n_i, clk_en_i, img_req_o, img_done_i;
  logic apply_req_o, apply_done_i, otp_req_o, otp_ack_i, otp_found_i;
  logic otp_crc_ok_i, otp_system_analog_pll_fb_i, hotfix_present_i, hotfix_req_o;
  logic hotfix_done_i, ee_probe_req_o, ee_probe_ack_i, ee_found_i;
  logic ee_blk_req_o, ee_blk_upd_o, ee_blk_ack_i, ee_blk_valid_i;
  logic system_analog_pll_cal_o, system_analog_pll_lock_req_o, system_analog_pll_locked_i, serial_en_o;
  logic outputs_en_o, monitors_en_o, alarms_en_o, done_o, ser_wr_i;
  logic page_wr_i, burst_end_i, user_space_o, select_or_addr0_pin_i;
  logic data_in_or_addr1_pin_i, sdio_i, sdio_o, sdio_oe_o, slv_sdo_i;
  logic slv_sdo_en_i, slave_addr_bit0_o, slave_addr_bit1_o, spi_cs_n_o;
  logic spi_di_o, sda_in_o;
  logic [5:0] strap_i;
  logic [3:0] otp_cfg_num_o, cfg_num_o, func_need_i, func_keep_i;
  logic [6:0] ee_addr_o;
  logic [1:0] ee_speed_o, ee_spd;
  logic [15:0] ee_blk_off_o, page_wdata_i, txn_off_i, reg_addr_o;
  logic [3:0][1:0] pwr_state_o;
  rcs_pkg::rcs_ser_cfg_t otp_ser_i, ser_wdata_i, ser_cfg_o;
  rcs_pkg::rcs_status_t status_o;
  logic [7:0] ee_mask;
  logic [2:0] blk_ok;
  int errors = 0, samples_checked = 0, n_probe, n_blk, n_img, n_cal;
  rcs_top rcs_top_i (.*);
  rcs_peer rcs_peer_i (.*);
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (ee_probe_req_o && ee_probe_ack_i) n_probe++;
    if (ee_blk_req_o && ee_blk_ack_i) n_blk++;
    if (img_req_o && img_done_i) n_img++;
    if (system_analog_pll_cal_o) n_cal++;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic boot(input logic [5:0] s, input logic [2:0] o,
      input logic [7:0] m, input logic [1:0] sp, input logic [2:0] b);
    cyc(1);
    strap_i = s;
    {otp_found_i, otp_crc_ok_i, otp_system_analog_pll_fb_i} = o;
    ee_mask = m;
    ee_spd = sp;
    blk_ok = b;
    arst_n_i = 1'b0;
    {n_probe, n_blk, n_img, n_cal} = '0;
    cyc(2);
    arst_n_i = 1'b1;
    for (int i = 0; i < 3000 && done_o !== 1'b1; i++) cyc(1);
    chk("done", 16'h1, done_o);
  endtask
  task automatic t_otp;
    otp_ser_i = 3'b001;
    boot(6'h14, 3'b111, 8'h00, 2'h0, 3'h0);
    chk("cfg_num", 16'h5, cfg_num_o);
    chk("status", 16'h0, status_o);
    chk("cal", 16'h1, n_cal);
    chk("ser_cfg", 16'h1, ser_cfg_o);
    {func_need_i, func_keep_i} = 8'h42;
    txn_off_i = 16'hc024;
    cyc(2);
    chk("full_addr", 16'hc024, reg_addr_o);
    chk("user", 16'h1, user_space_o);
    chk("pwr", 16'h24, pwr_state_o);
    {ser_wr_i, ser_wdata_i, page_wr_i, page_wdata_i} = {4'h8, 17'h1cb00};
    cyc(1);
    {ser_wr_i, page_wr_i, burst_end_i} = 3'b001;
    cyc(1);
    burst_end_i = 1'b0;
    txn_off_i = 16'h00e4;
    select_or_addr0_pin_i = 1'b1;
    cyc(5);
    chk("paged", 16'hcbe4, reg_addr_o);
    chk("ser_new", 16'h0, ser_cfg_o);
    chk("addr0", 16'h1, slave_addr_bit0_o);
    chk("sda_oe", 16'h1, sdio_oe_o);
  endtask
  task automatic t_spi;
    select_or_addr0_pin_i = 1'b0;
    boot(6'h03, 3'b100, 8'h00, 2'h0, 3'h0);
    chk("bad_crc", 16'h1, status_o.otp_bad_crc);
    chk("no_ee", 16'h1, status_o.no_eeprom);
    chk("no_cfg", 16'h1, status_o.no_cfg);
    chk("probes", 16'd24, n_probe);
    chk("spi", 16'h1, ser_cfg_o.proto_spi);
    chk("four_wire", 16'h0, ser_cfg_o.spi_3wire);
    cyc(5);
    chk("cs_n", 16'h0, spi_cs_n_o);
  endtask
  task automatic t_ee;
    hotfix_present_i = 1'b1;
    boot(6'h02, 3'b000, 8'h08, 2'h1, 3'b010);
    chk("probes", 16'd16, n_probe);
    chk("blocks", 16'd3, n_blk);
    chk("status", 16'h20, status_o);
    chk("images", 16'h1, n_img);
  endtask
  task automatic t_upd;
    hotfix_present_i = 1'b0;
    boot(6'h02, 3'b000, 8'h01, 2'h0, 3'b100);
    chk("upd", 16'h1, status_o.upd_applied);
    chk("images", 16'h2, n_img);
    chk("probes", 16'd16, n_probe);
    chk("no_cfg", 16'h1, status_o.no_cfg);
  endtask
  initial begin
    {arst_n_i, otp_ser_i, hotfix_present_i, func_need_i, func_keep_i} = '0;
    {ser_wr_i, ser_wdata_i, page_wr_i, page_wdata_i, burst_end_i} = '0;
    {txn_off_i, select_or_addr0_pin_i, data_in_or_addr1_pin_i} = '0;
    {sdio_i, slv_sdo_i, slv_sdo_en_i, strap_i, ee_mask, ee_spd} = '0;
    {otp_found_i, otp_crc_ok_i, otp_system_analog_pll_fb_i, blk_ok} = '0;
    clk_en_i = 1'b1;
    t_otp();
    t_spi();
    t_ee();
    t_upd();
    end_sim();
  end
  initial begin
    #3000000;
    errors++;
    end_sim();
  end
endmodule
